// >>> bench/opk_plc_model.sv
// opk_plc_model: controller side, an axi4-lite master doing single reads and writes
// assumes the slave answers every request; the bench watchdog ends a hang
module opk_plc_model
(
  // clock
  input  wire logic        mclk,
  // axi4-lite master
  output logic [7:0]       s_awaddr,
  output logic             s_awvalid,
  input  wire logic        s_awready,
  output logic [31:0]      s_wdata,
  output logic [3:0]       s_wstrb,
  output logic             s_wvalid,
  input  wire logic        s_wready,
  input  wire logic        s_bvalid,
  output logic             s_bready,
  output logic [7:0]       s_araddr,
  output logic             s_arvalid,
  input  wire logic        s_arready,
  input  wire logic        s_rvalid,
  output logic             s_rready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {s_awaddr, s_awvalid, s_wdata, s_wvalid, s_bready} = '0;
    {s_araddr, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hf;
  end

  // address and data go out together, each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ah;
    bit wh;
    @(posedge mclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    ah = 1;
    wh = 1;
    while (ah || wh)
    begin
      @(posedge mclk);
      if (ah && s_awready)
      begin
        s_awvalid <= 1'b0;
        ah = 0;
      end
      if (wh && s_wready)
      begin
        s_wvalid <= 1'b0;
        wh = 0;
      end
    end
    do @(posedge mclk); while (!s_bvalid);
    s_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do @(posedge mclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_rvalid);
    s_rready <= 1'b0;
  endtask : rd
endmodule : opk_plc_model

// >>> bench/testbench.sv
// testbench: drives panel pins, reads results back through the controller model
// assumes shortened fail-safe and link timeouts of 50 cycles
module testbench;
  import opk_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 0, srst = 1, clk_en = 1, enable_pin = 0, link_alive = 1;
  logic [OPK_NSRC-1:0] src_pin = '0;
  opk_fs_type          fs_pin  = '1;
  opk_led_type         led_out;
  logic [OPK_NFS-1:0]  fs_report, fta, ftb;
  logic [1:0]          rsp_q[$], rrs;
  logic [OPK_NSRC-1:0] key_report;
  logic irq, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, rnd, m;
  logic [3:0]  ws;
  logic [31:0] exp_q[$], msk_q[$];
  int err_count = 0, num_checks = 0, seed = 32'hb72c, idx;

  always #2.5 mclk = ~mclk;

  opk_key_io #(.DISC_CYC(50), .COMM_CYC(50)) i_opk_key_io (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .src_pin(src_pin), .enable_pin(enable_pin),
    .fs_pin(fs_pin), .link_alive(link_alive), .fs_test_out_a(fta), .fs_test_out_b(ftb),
    .led_out(led_out), .key_report(key_report), .fs_report(fs_report), .irq(irq),
    .s_awaddr(awa), .s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(ws),
    .s_wvalid(wv), .s_wready(wr_), .s_bresp(), .s_bvalid(bv), .s_bready(br),
    .s_araddr(ara), .s_arvalid(arv), .s_arready(arr), .s_rdata(rdat), .s_rresp(rrs),
    .s_rvalid(rv), .s_rready(rr));

  opk_plc_model i_opk_plc_model (
    .mclk(mclk), .s_awaddr(awa), .s_awvalid(awv), .s_awready(awr), .s_wdata(wd),
    .s_wstrb(ws), .s_wvalid(wv), .s_wready(wr_), .s_bvalid(bv), .s_bready(br),
    .s_araddr(ara), .s_arvalid(arv), .s_arready(arr), .s_rvalid(rv), .s_rready(rr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // expectation noted before the read; only masked bits are judged
  task automatic rdq(logic [7:0] a, logic [31:0] e, logic [31:0] k);
    exp_q.push_back(e);
    msk_q.push_back(k);
    rsp_q.push_back(a > OPK_REG_FLASHDIV ? 2'b10 : 2'b00);
    i_opk_plc_model.rd(a);
  endtask : rdq

  task automatic tap(int i);
    src_pin[i] <= 1'b1;
    cyc(10);
    src_pin[i] <= 1'b0;
    cyc(10);
  endtask : tap

  always @(posedge mclk)
    if (rv && rr)
    begin
      if (exp_q.size() == 0)
        chk("unexpected read", 32'h0, 32'hffff_ffff);
      else
      begin
        chk("read resp", {30'h0, rsp_q.pop_front()}, {30'h0, rrs});
        chk("read data", exp_q.pop_front(), rdat & msk_q.pop_front());
      end
    end

  initial
  begin
    cyc(20000);
    err_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(8);
    srst <= 1'b0;
    cyc(2);
    rdq(OPK_REG_MODE, 32'h0, '1);
    rdq(8'h40, 32'h0, '1);
    src_pin[0] <= 1'b1;
    cyc(10);
    rdq(OPK_REG_KEYSTATE, 32'h1, 32'h1);
    src_pin[0] <= 1'b0;
    cyc(10);
    rdq(OPK_REG_KEYSTATE, 32'h0, 32'h1);
    idx = 16 + ($unsigned($random(seed)) % 14);
    m = 32'h1 << idx;
    i_opk_plc_model.wr(OPK_REG_MODE, m);
    tap(idx);
    rdq(OPK_REG_KEYSTATE, m, m);
    tap(idx);
    rdq(OPK_REG_KEYSTATE, 32'h0, m);
    // four fail-safe channels, all contacts closed
    i_opk_plc_model.wr(OPK_REG_CTRL, 32'h6);
    cyc(10);
    chk("fs_report", 32'hf, {28'h0, fs_report});
    chk("fs_test_out", 32'hff, {24'h0, fta, ftb});
    src_pin[1] <= 1'b1;
    cyc(10);
    enable_pin <= 1'b1;
    cyc(10);
    src_pin[1] <= 1'b0;
    fs_pin.ch_a[0] <= 1'b0;
    cyc(60);
    rdq(OPK_REG_KEYSTATE, 32'h2, 32'h2);
    chk("fs_report", 32'he, {28'h0, fs_report});
    rdq(OPK_REG_FSSTATE, 32'h10, 32'h10);
    fs_pin <= '1;
    enable_pin <= 1'b0;
    cyc(10);
    rdq(OPK_REG_KEYSTATE, 32'h0, 32'h2);
    chk("fs_report", 32'hf, {28'h0, fs_report});
    rnd = $random(seed);
    i_opk_plc_model.wr(OPK_REG_LEDCOL0, 32'h0);
    i_opk_plc_model.wr(OPK_REG_LEDFLASH, 32'h0);
    i_opk_plc_model.wr(OPK_REG_LEDBITS, {16'h0, rnd[15:0]});
    cyc(3);
    chk("led red", {16'h0, rnd[15:0]}, {16'h0, led_out.red});
    chk("led green", 32'h0, {16'h0, led_out.green});
    i_opk_plc_model.wr(OPK_REG_LEDCOL0, 32'h2);
    cyc(3);
    chk("led green", {31'h0, rnd[0]}, {16'h0, led_out.green});
    i_opk_plc_model.wr(OPK_REG_FLASHDIV, 32'h4);
    i_opk_plc_model.wr(OPK_REG_LEDFLASH, 32'h1);
    i_opk_plc_model.wr(OPK_REG_LEDBITS, 32'h1);
    cyc(2);
    m = {31'h0, led_out.green[0]};
    cyc(5);
    chk("led flash", ~m & 32'h1, {31'h0, led_out.green[0]});
    i_opk_plc_model.wr(OPK_REG_IRQEN, 32'h1);
    link_alive <= 1'b0;
    cyc(60);
    chk("irq", 32'h1, {31'h0, irq});
    link_alive <= 1'b1;
    i_opk_plc_model.wr(OPK_REG_IRQEN, 32'h0);
    cyc(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    i_opk_plc_model.wr(OPK_REG_IRQCLR, 32'h1);
    i_opk_plc_model.wr(OPK_REG_IRQEN, 32'h1);
    cyc(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdq(OPK_REG_IRQSTAT, 32'h0, 32'h1);
    clk_en <= 1'b0;
    src_pin[2] <= 1'b1;
    cyc(10);
    chk("key frozen", 32'h0, {31'h0, key_report[2]});
    clk_en <= 1'b1;
    cyc(10);
    chk("key thawed", 32'h1, {31'h0, key_report[2]});
    src_pin[2] <= 1'b0;
    // one-microsecond stretch of an eight-cycle press
    i_opk_plc_model.wr(OPK_REG_STRETCH, 32'h1);
    i_opk_plc_model.wr(OPK_REG_CTRL, 32'h7);
    src_pin[3] <= 1'b1;
    cyc(8);
    src_pin[3] <= 1'b0;
    cyc(30);
    rdq(OPK_REG_KEYSTATE, 32'h8, 32'h8);
    cyc(5);
    tally_and_finish();
  end
endmodule : testbench

// >>> hw/opk_key_io.sv
// opk_key_io: operator panel keys, standard inputs, key leds and e-stop channels
// assumes key and input pins are asynchronous and already electrically debounced,
// and that a host bridge reaches the registers over axi4-lite on mclk
//
// Overview of operation
// (R1) button mode: bit follows key level
// (R2) switch mode: each press-release toggles bit
// (R3) each digital input selects button or switch
// (R4) reset puts all sources in button mode
// (R5) optional stretch holds short activations reported
// (R6) key led lights when its bit set
// (R7) led steady or flashing, red green yellow
// (R8) enable lock stops forwarding input transitions
// (R9) locked state keeps reporting pre-lock key values
// (R10) e-stop channels ignore enable lock
// (R11) one to four two-channel e-stop channels
// (R12) each channel monitored on two inputs
// (R13) fault forces channel safe, two-of-two
// (R14) report comm, hardware, configuration faults
// (R15) diagnostics always active, delivered automatically
// (R16) standard and fail-safe paths run concurrently
// (R17) at most fourteen standard inputs used
// (R18) one shared flash timebase for all leds
module opk_key_io
  import opk_pkg::*;
#(
  parameter int DISC_CYC  = OPK_DISC_CYC,
  parameter int COMM_CYC  = OPK_COMM_CYC
)
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic                  clk_en,
  // panel pins
  input  wire logic [OPK_NSRC-1:0]   src_pin,
  input  wire logic                  enable_pin,
  input  wire opk_fs_type            fs_pin,
  input  wire logic                  link_alive,
  output logic       [OPK_NFS-1:0]   fs_test_out_a,
  output logic       [OPK_NFS-1:0]   fs_test_out_b,
  output opk_led_type                led_out,
  // reported states
  output logic       [OPK_NSRC-1:0]  key_report,
  output logic       [OPK_NFS-1:0]   fs_report,
  output logic                       irq,
  // axi4-lite slave
  input  wire logic [7:0]            s_awaddr,
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [31:0]           s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  output logic [1:0]                 s_bresp,
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  input  wire logic [7:0]            s_araddr,
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  output logic [31:0]                s_rdata,
  output logic [1:0]                 s_rresp,
  output logic                       s_rvalid,
  input  wire logic                  s_rready
);

  localparam int NSY = OPK_NSRC + 1 + 2 * OPK_NFS;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: a change counts once stages two and three agree
  logic [NSY-1:0] sy1_r, sy2_r, sy3_r, filt_r;
  logic [NSY-1:0] sy1_nxt, sy2_nxt, sy3_nxt, filt_nxt;
  logic [NSY-1:0] raw_in;

  assign raw_in = {fs_pin.ch_b, fs_pin.ch_a, enable_pin, src_pin};

  always_comb
  begin
    sy1_nxt  = raw_in;
    sy2_nxt  = sy1_r;
    sy3_nxt  = sy2_r;
    filt_nxt = filt_r;
    for (int i = 0; i < NSY; i++)
    begin
      if (sy2_r[i] == sy3_r[i])
        filt_nxt[i] = sy3_r[i];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sy1_r  <= '0;
      sy2_r  <= '0;
      sy3_r  <= '0;
      filt_r <= '0;
    end
    else if (clk_en)
    begin
      sy1_r  <= sy1_nxt;
      sy2_r  <= sy2_nxt;
      sy3_r  <= sy3_nxt;
      filt_r <= filt_nxt;
    end
  end

  logic [OPK_NSRC-1:0] src_lvl;
  logic                locked;
  logic [OPK_NFS-1:0]  fs_a, fs_b;
  assign src_lvl = filt_r[OPK_NSRC-1:0];
  assign locked  = filt_r[OPK_NSRC];  // enable pin high selects monitoring mode
  assign fs_a    = filt_r[OPK_NSRC+1 +: OPK_NFS];
  assign fs_b    = filt_r[OPK_NSRC+1+OPK_NFS +: OPK_NFS];

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [31:0] mode_r, mode_nxt;
  logic [15:0] stretch_r, stretch_nxt;
  logic [3:0]  ctrl_r, ctrl_nxt;
  logic [OPK_NKEY-1:0] ledbits_r, ledbits_nxt, ledflash_r, ledflash_nxt;
  logic [31:0] ledcol0_r, ledcol0_nxt, ledcol1_r, ledcol1_nxt;
  logic [23:0] flashdiv_r, flashdiv_nxt;
  logic [OPK_NEVT-1:0] irq_stat_r, irq_stat_nxt, irq_en_r, irq_en_nxt;
  logic [OPK_NEVT-1:0] evt;

  ////////////////////////////////////////////////////////////////////////////
  // per source conditioning
  logic [OPK_NSRC-1:0] prev_r, prev_nxt, tog_r, tog_nxt, rep_r, rep_nxt;
  logic [15:0]         str_cnt_r [OPK_NSRC];
  logic [15:0]         str_cnt_nxt [OPK_NSRC];
  logic [7:0]          tick_cnt_r, tick_cnt_nxt;
  logic                us_tick;

  assign us_tick = (tick_cnt_r == 8'(OPK_STRETCH_TICK - 1));

  genvar g;
  generate
    for (g = 0; g < OPK_NSRC; g++)
    begin : g_src
      logic act;
      always_comb
      begin
        prev_nxt[g] = src_lvl[g];
        tog_nxt[g]  = tog_r[g];
        if (prev_r[g] && !src_lvl[g])
          tog_nxt[g] = ~tog_r[g];  // R2
        act = mode_r[g] ? tog_nxt[g] : src_lvl[g];  // R1 R3
        str_cnt_nxt[g] = str_cnt_r[g];
        // one spare unit: the shared tick runs free, so a plain load could end a unit early
        if (act && !rep_r[g])
          str_cnt_nxt[g] = (stretch_r == 16'h0000 || stretch_r == 16'hffff) ? stretch_r
                                                                            : stretch_r + 16'h0001;
        else if (us_tick && str_cnt_r[g] != 16'h0000)
          str_cnt_nxt[g] = str_cnt_r[g] - 16'h0001;
        rep_nxt[g] = act;
        if (ctrl_r[OPK_CTRL_STRETCH_EN] && rep_r[g] && str_cnt_r[g] != 16'h0000)
          rep_nxt[g] = 1'b1;  // R5
        if (locked)
        begin
          // R8 R9
          prev_nxt[g]    = prev_r[g];
          tog_nxt[g]     = tog_r[g];
          rep_nxt[g]     = rep_r[g];
          str_cnt_nxt[g] = str_cnt_r[g];
        end
      end
      always_ff @(posedge mclk)
      begin
        if (srst)
          str_cnt_r[g] <= 16'h0000;
        else if (clk_en)
          str_cnt_r[g] <= str_cnt_nxt[g];
      end
    end
  endgenerate

  always_comb
  begin
    tick_cnt_nxt = us_tick ? 8'h00 : tick_cnt_r + 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      prev_r     <= '0;
      tog_r      <= '0;
      rep_r      <= '0;
      tick_cnt_r <= 8'h00;
    end
    else if (clk_en)
    begin
      prev_r     <= prev_nxt;
      tog_r      <= tog_nxt;
      rep_r      <= rep_nxt;
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fail-safe channels, never gated by the lock (R10 R16)
  logic [OPK_NFS-1:0] fs_on, fs_fault_r, fs_fault_nxt, fs_rep_r, fs_rep_nxt;
  logic [31:0]        disc_r [OPK_NFS];
  logic [31:0]        disc_nxt [OPK_NFS];
  logic [31:0]        comm_cnt_r, comm_cnt_nxt;
  logic               comm_fault_r, comm_fault_nxt;

  generate
    for (g = 0; g < OPK_NFS; g++)
    begin : g_fs
      assign fs_on[g] = (2'(g) <= ctrl_r[OPK_CTRL_FS_CH_LO +: 2]);  // R11
      always_comb
      begin
        disc_nxt[g]     = (fs_a[g] != fs_b[g]) ? disc_r[g] + 32'h1 : 32'h0;  // R12
        fs_fault_nxt[g] = fs_fault_r[g];
        if (fs_on[g] && disc_r[g] >= 32'(DISC_CYC))
          fs_fault_nxt[g] = 1'b1;
        else if (fs_a[g] && fs_b[g])
          fs_fault_nxt[g] = 1'b0;  // both closed again reintegrates
        // break contacts: both closed means released; any fault or open gives stop
        fs_rep_nxt[g] = fs_on[g] & fs_a[g] & fs_b[g] & ~fs_fault_nxt[g];  // R13
      end
      always_ff @(posedge mclk)
      begin
        if (srst)
          disc_r[g] <= 32'h0;
        else if (clk_en)
          disc_r[g] <= disc_nxt[g];
      end
    end
  endgenerate

  always_comb
  begin
    comm_cnt_nxt   = link_alive ? 32'h0 : comm_cnt_r + 32'h1;
    comm_fault_nxt = (comm_cnt_r >= 32'(COMM_CYC));
    evt[OPK_EV_COMM] = comm_fault_r;  // R14 R15
    evt[OPK_EV_HW]   = |fs_fault_r;
    evt[OPK_EV_CFG]  = ctrl_r[OPK_CTRL_CFG_ERR];
    evt[OPK_EV_KEY]  = |(rep_r ^ key_report);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      fs_fault_r   <= '0;
      fs_rep_r     <= '0;
      comm_cnt_r   <= 32'h0;
      comm_fault_r <= 1'b0;
    end
    else if (clk_en)
    begin
      fs_fault_r   <= fs_fault_nxt;
      fs_rep_r     <= fs_rep_nxt;
      comm_cnt_r   <= comm_cnt_nxt;
      comm_fault_r <= comm_fault_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // leds: one shared flash phase
  logic [23:0] flash_cnt_r, flash_cnt_nxt;
  logic        flash_ph_r, flash_ph_nxt;
  logic [23:0] flash_lim;
  opk_led_type led_nxt;

  assign flash_lim = (flashdiv_r == 24'h0) ? 24'(OPK_FLASH_CYC / 256) : flashdiv_r;

  always_comb
  begin
    flash_cnt_nxt = flash_cnt_r + 24'h1;
    flash_ph_nxt  = flash_ph_r;
    if (flash_cnt_r >= flash_lim)
    begin
      flash_cnt_nxt = 24'h0;
      flash_ph_nxt  = ~flash_ph_r;  // R18
    end
    for (int i = 0; i < OPK_NKEY; i++)
    begin
      logic        on;
      opk_col_type col;
      on  = ledbits_r[i] & (~ledflash_r[i] | flash_ph_r);  // R6 R7
      col = opk_col_type'(i < 16 ? ledcol0_r[2*(i%16) +: 2] : ledcol1_r[2*(i%16) +: 2]);
      led_nxt.red[i]   = on & (col == OPK_COL_RED || col == OPK_COL_YELLOW);  // R7
      led_nxt.green[i] = on & (col == OPK_COL_GREEN || col == OPK_COL_YELLOW);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read at a time
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic        bvalid_nxt, rvalid_nxt, awready_nxt, wready_nxt, arready_nxt;
  logic [31:0] rdata_nxt, rd_val;
  logic        rd_ok, do_wr;
  logic [7:0]  rd_addr;

  assign do_wr   = aw_hold_r && w_hold_r && !s_bvalid;
  assign rd_addr = s_araddr;

  always_comb
  begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    case (rd_addr)
      OPK_REG_CTRL:     rd_val = {28'h0, ctrl_r};
      OPK_REG_MODE:     rd_val = mode_r;
      OPK_REG_STRETCH:  rd_val = {16'h0, stretch_r};
      OPK_REG_KEYSTATE: rd_val = {2'h0, key_report};
      OPK_REG_LEDBITS:  rd_val = {16'h0, ledbits_r};
      OPK_REG_LEDFLASH: rd_val = {16'h0, ledflash_r};
      OPK_REG_LEDCOL0:  rd_val = ledcol0_r;
      OPK_REG_LEDCOL1:  rd_val = ledcol1_r;
      OPK_REG_FSSTATE:  rd_val = {24'h0, fs_fault_r, fs_rep_r};
      OPK_REG_DIAG:     rd_val = {28'h0, evt};
      OPK_REG_IRQSTAT:  rd_val = {28'h0, irq_stat_r};
      OPK_REG_IRQEN:    rd_val = {28'h0, irq_en_r};
      OPK_REG_IRQCLR:   rd_val = 32'h0;
      OPK_REG_FLASHDIV: rd_val = {8'h0, flashdiv_r};
      default:          rd_ok  = 1'b0;
    endcase
  end

  always_comb
  begin
    aw_hold_nxt  = aw_hold_r;
    w_hold_nxt   = w_hold_r;
    awaddr_nxt   = awaddr_r;
    wdata_nxt    = wdata_r;
    bvalid_nxt   = s_bvalid;
    bresp_nxt    = s_bresp;
    rvalid_nxt   = s_rvalid;
    rresp_nxt    = s_rresp;
    rdata_nxt    = s_rdata;
    mode_nxt     = mode_r;
    stretch_nxt  = stretch_r;
    ctrl_nxt     = ctrl_r;
    ledbits_nxt  = ledbits_r;
    ledflash_nxt = ledflash_r;
    ledcol0_nxt  = ledcol0_r;
    ledcol1_nxt  = ledcol1_r;
    flashdiv_nxt = flashdiv_r;
    irq_en_nxt   = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    if (s_awvalid && s_awready)
    begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_awaddr;
    end
    if (s_wvalid && s_wready)
    begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_wdata;
    end
    if (s_bvalid && s_bready)
      bvalid_nxt = 1'b0;
    if (do_wr)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = 2'b00;
      case (awaddr_r)
        OPK_REG_CTRL:     ctrl_nxt     = wdata_r[3:0];
        OPK_REG_MODE:     mode_nxt     = {2'h0, wdata_r[OPK_NSRC-1:0]};
        OPK_REG_STRETCH:  stretch_nxt  = wdata_r[15:0];
        OPK_REG_LEDBITS:  ledbits_nxt  = wdata_r[15:0];
        OPK_REG_LEDFLASH: ledflash_nxt = wdata_r[15:0];
        OPK_REG_LEDCOL0:  ledcol0_nxt  = wdata_r;
        OPK_REG_LEDCOL1:  ledcol1_nxt  = wdata_r;
        OPK_REG_IRQEN:    irq_en_nxt   = wdata_r[OPK_NEVT-1:0];
        OPK_REG_IRQCLR:   irq_stat_nxt = irq_stat_r & ~wdata_r[OPK_NEVT-1:0];
        OPK_REG_FLASHDIV: flashdiv_nxt = wdata_r[23:0];
        OPK_REG_KEYSTATE, OPK_REG_FSSTATE, OPK_REG_DIAG, OPK_REG_IRQSTAT: ;
        default:          bresp_nxt    = 2'b10;
      endcase
    end
    irq_stat_nxt = irq_stat_nxt | evt;  // set beats clear
    if (s_rvalid && s_rready)
      rvalid_nxt = 1'b0;
    if (s_arvalid && s_arready)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_ok ? rd_val : 32'h0;
      rresp_nxt  = rd_ok ? 2'b00 : 2'b10;
    end
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt  = !w_hold_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0;
      s_awready     <= 1'b0;
      s_wready      <= 1'b0;
      s_arready     <= 1'b0;
      s_bvalid      <= 1'b0;
      s_bresp       <= 2'b00;
      s_rvalid      <= 1'b0;
      s_rresp       <= 2'b00;
      s_rdata       <= 32'h0;
      mode_r        <= OPK_MODE_RST;  // R4
      stretch_r     <= OPK_STRETCH_RST;
      ctrl_r        <= 4'h0;
      ledbits_r     <= '0;
      ledflash_r    <= '0;
      ledcol0_r     <= 32'h0;
      ledcol1_r     <= 32'h0;
      flashdiv_r    <= OPK_FLASHDIV_RST;
      irq_en_r      <= '0;
      irq_stat_r    <= '0;
      flash_cnt_r   <= 24'h0;
      flash_ph_r    <= 1'b0;
      led_out       <= '0;
      key_report    <= '0;
      fs_report     <= '0;
      fs_test_out_a <= '0;
      fs_test_out_b <= '0;
      irq           <= 1'b0;
    end
    else if (clk_en)
    begin
      aw_hold_r     <= aw_hold_nxt;
      w_hold_r      <= w_hold_nxt;
      awaddr_r      <= awaddr_nxt;
      wdata_r       <= wdata_nxt;
      s_awready     <= awready_nxt;
      s_wready      <= wready_nxt;
      s_arready     <= arready_nxt;
      s_bvalid      <= bvalid_nxt;
      s_bresp       <= bresp_nxt;
      s_rvalid      <= rvalid_nxt;
      s_rresp       <= rresp_nxt;
      s_rdata       <= rdata_nxt;
      mode_r        <= mode_nxt;
      stretch_r     <= stretch_nxt;
      ctrl_r        <= ctrl_nxt;
      ledbits_r     <= ledbits_nxt;
      ledflash_r    <= ledflash_nxt;
      ledcol0_r     <= ledcol0_nxt;
      ledcol1_r     <= ledcol1_nxt;
      flashdiv_r    <= flashdiv_nxt;
      irq_en_r      <= irq_en_nxt;
      irq_stat_r    <= irq_stat_nxt;
      flash_cnt_r   <= flash_cnt_nxt;
      flash_ph_r    <= flash_ph_nxt;
      led_out       <= led_nxt;
      key_report    <= rep_r;  // R17
      fs_report     <= fs_rep_r;
      fs_test_out_a <= fs_on;   // drive the contact feeds of active channels
      fs_test_out_b <= fs_on;
      irq           <= |(irq_stat_nxt & irq_en_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_lock_freeze: assert property (@(posedge mclk) disable iff (srst)  // R9
    clk_en && locked && $past(clk_en) && $past(locked) |-> rep_r == $past(rep_r))
    else $error("report changed while locked");
  a_button_follow: assert property (@(posedge mclk) disable iff (srst)  // R1
    clk_en && !locked && !mode_r[0] && !ctrl_r[OPK_CTRL_STRETCH_EN] && $past(clk_en)
      && !$past(locked) |-> rep_r[0] == $past(src_lvl[0]))
    else $error("button report does not follow key");
  a_switch_toggle: assert property (@(posedge mclk) disable iff (srst)  // R2
    clk_en && !locked && prev_r[0] && !src_lvl[0] |=> !clk_en || tog_r[0] != $past(tog_r[0]))
    else $error("switch did not toggle on release");
  a_fs_safe: assert property (@(posedge mclk) disable iff (srst)  // R13
    fs_fault_r[0] |-> !fs_rep_r[0] || !clk_en)
    else $error("faulted channel not safe");
  a_fs_mismatch: assert property (@(posedge mclk) disable iff (srst)  // R12
    clk_en && fs_a[0] != fs_b[0] |=> !clk_en || !fs_rep_r[0])
    else $error("mismatched contacts reported closed");
  a_led_dark: assert property (@(posedge mclk) disable iff (srst)  // R6
    clk_en && !ledbits_r[0] |=> !clk_en || (!led_out.red[0] && !led_out.green[0]))
    else $error("led lit with bit clear");
  a_diag_irq: assert property (@(posedge mclk) disable iff (srst)  // R15
    clk_en && evt[OPK_EV_HW] |=> !clk_en || irq_stat_r[OPK_EV_HW])
    else $error("hardware fault not latched");
  a_reset_mode: assert property (@(posedge mclk)  // R4
    srst |=> mode_r == OPK_MODE_RST)
    else $error("mode not cleared by reset");
  c_lock: cover property (@(posedge mclk) disable iff (srst) locked && rep_r[0]);
  c_fs_fault: cover property (@(posedge mclk) disable iff (srst) fs_fault_r[0]);
  c_flash: cover property (@(posedge mclk) disable iff (srst) $rose(flash_ph_r));

endmodule : opk_key_io

// >>> hw/opk_pkg.sv
// opk_pkg: constants, register map and carrier types of the operator panel key/io block
// assumes a 200 MHz mclk and a 32-bit axi4-lite register port
package opk_pkg;

  localparam int          OPK_NKEY       = 16;  // front keys
  localparam int          OPK_NDIN       = 14;  // standard digital inputs usable
  localparam int          OPK_NSRC       = OPK_NKEY + OPK_NDIN;
  localparam int          OPK_NFS        = 4;   // fail-safe channels
  localparam int          OPK_NEVT       = 4;

  // register byte offsets
  localparam logic [7:0]  OPK_REG_CTRL     = 8'h00;
  localparam logic [7:0]  OPK_REG_MODE     = 8'h04;
  localparam logic [7:0]  OPK_REG_STRETCH  = 8'h08;
  localparam logic [7:0]  OPK_REG_KEYSTATE = 8'h0c;
  localparam logic [7:0]  OPK_REG_LEDBITS  = 8'h10;
  localparam logic [7:0]  OPK_REG_LEDFLASH = 8'h14;
  localparam logic [7:0]  OPK_REG_LEDCOL0  = 8'h18;
  localparam logic [7:0]  OPK_REG_LEDCOL1  = 8'h1c;
  localparam logic [7:0]  OPK_REG_FSSTATE  = 8'h20;
  localparam logic [7:0]  OPK_REG_DIAG     = 8'h24;
  localparam logic [7:0]  OPK_REG_IRQSTAT  = 8'h28;
  localparam logic [7:0]  OPK_REG_IRQEN    = 8'h2c;
  localparam logic [7:0]  OPK_REG_IRQCLR   = 8'h30;
  localparam logic [7:0]  OPK_REG_FLASHDIV = 8'h34;

  // ctrl fields
  localparam int          OPK_CTRL_STRETCH_EN = 0;
  localparam int          OPK_CTRL_FS_CH_LO   = 1;   // active fs channel count - 1, 2 bits
  localparam int          OPK_CTRL_CFG_ERR    = 3;   // software-reported config error

  // diag / irq event positions
  localparam int          OPK_EV_COMM   = 0;
  localparam int          OPK_EV_HW     = 1;
  localparam int          OPK_EV_CFG    = 2;
  localparam int          OPK_EV_KEY    = 3;

  // reset values
  localparam logic [31:0] OPK_MODE_RST     = 32'h0000_0000;  // all momentary
  localparam logic [15:0] OPK_STRETCH_RST  = 16'h0000;
  localparam logic [23:0] OPK_FLASHDIV_RST = 24'h00_0000;

  // timing
  localparam int          OPK_CLK_MHZ       = 200;
  localparam int          OPK_STRETCH_US    = 1;     // stretch unit, microseconds
  localparam int          OPK_STRETCH_TICK  = OPK_STRETCH_US * OPK_CLK_MHZ;
  localparam int          OPK_DISC_MS       = 20;    // fs channel discrepancy time
  localparam int          OPK_DISC_CYC      = OPK_DISC_MS * OPK_CLK_MHZ * 1000;
  localparam int          OPK_FLASH_MS      = 250;   // flash base; default half period is 1/256 of it
  localparam int          OPK_FLASH_CYC     = OPK_FLASH_MS * OPK_CLK_MHZ * 1000;
  localparam int          OPK_COMM_MS       = 100;   // link watchdog
  localparam int          OPK_COMM_CYC      = OPK_COMM_MS * OPK_CLK_MHZ * 1000;

  typedef enum logic [1:0] {OPK_COL_RED, OPK_COL_GREEN, OPK_COL_YELLOW, OPK_COL_OFF} opk_col_type;

  typedef struct packed
  {
    logic [OPK_NFS-1:0] ch_a;
    logic [OPK_NFS-1:0] ch_b;
  } opk_fs_type;

  typedef struct packed
  {
    logic [OPK_NKEY-1:0] red;
    logic [OPK_NKEY-1:0] green;
  } opk_led_type;

endpackage : opk_pkg
